// *** rtl/sample_rec_map.svh ***
/*
   Register offsets, field positions, reset values and timing figures of the
   two-channel totalize sample recorder. Definitions only; no logic.
*/
`ifndef SAMPLE_REC_MAP_SVH
`define SAMPLE_REC_MAP_SVH

// register offsets on the plain register port
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_SAMPLES 8'h08
`define REG_CNT_A 8'h0C
`define REG_CNT_B 8'h10
`define REG_TIME 8'h14

// control register bits
`define CTRL_EN_BIT 0
`define CTRL_INH_BIT 1
`define CTRL_BLK_BIT 2
`define CTRL_CLR_BIT 3

// status register bits
`define STAT_BUSY_BIT 0
`define STAT_MISS_BIT 1

// interpolator/status field of a record
`define FLD_INH_BIT 12
`define FLD_PICK_A_BIT 13
`define FLD_PICK_B_BIT 14
`define FLD_BLK_BIT 15
`define FLD_STAT1_MASK 32'h0000_9000

// record layout
`define N_FIELDS 4
`define N_WORDS 8
`define FLD_CNT_B 0
`define FLD_CNT_A 1
`define FLD_TIME 2
`define FLD_STAT 3

// reset values and steps
`define WORD_ZERO 32'h0000_0000
`define CNT_STEP 32'h0000_0001

// time datum counts 2 ns units; the clock runs at 10 ns
`define CLK_PERIOD_PS 10000
`define TIME_LSB_PS 2000
`define TIME_STEP (`CLK_PERIOD_PS / `TIME_LSB_PS)

`endif

// *** rtl/totalize_pkg.sv ***
/*
   Types shared by the totalize sample recorder modules.
   Assumes the map header supplies all figures.
*/
package totalize_pkg;
   typedef logic [31:0] word_t;
   typedef logic [31:0] count_t;
   typedef logic [11:0] interp_t;
   typedef logic [7:0] reg_addr_t;
   typedef logic [3:0] left_t;
   typedef enum {ST_IDLE, ST_CAP2} state_t;
endpackage : totalize_pkg

// *** rtl/rec_if.sv ***
/*
   Carrier of one finished sample (both capture attempts) from the
   capture logic to the record serializer. Assumes one common clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface rec_if;
   import totalize_pkg::*;
   logic load;
   word_t [3:0] att1;
   word_t [3:0] att2;
   logic busy;
   modport src (output load, output att1, output att2, input busy);
   modport snk (input load, input att1, input att2, output busy);
endinterface : rec_if
`default_nettype wire

// *** rtl/event_counter.sv ***
/*
   Free-running event counter for one input channel.
   Assumes evt is a one-cycle pulse synchronous to clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sample_rec_map.svh"
module event_counter
   import totalize_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire logic clear,
   input wire logic evt,
   output count_t count_ff
);

   // plain binary wrap; the consumer undoes rollovers
   always_ff @(posedge clock) begin
      if (srst || clear) begin
         count_ff <= `WORD_ZERO;
      end else if (evt) begin
         count_ff <= count_ff + `CNT_STEP;
      end
   end

endmodule : event_counter
`default_nettype wire

// *** rtl/record_serializer.sv ***
/*
   Sends one sample as eight 32-bit words: first attempt fields 0..3, then
   second attempt fields 0..3. Assumes a load only arrives while not busy.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sample_rec_map.svh"
module record_serializer
   import totalize_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   rec_if.snk rif,
   output logic rec_valid,
   output word_t rec_data,
   output logic rec_last,
   input wire logic rec_ready
);

   word_t buf_ff [`N_WORDS];
   left_t left_ff;

   assign rif.busy = (left_ff != 4'h0);
   assign rec_valid = rif.busy;
   assign rec_last = (left_ff == 4'h1);
   assign rec_data = buf_ff[0];

   always_ff @(posedge clock) begin
      if (srst) begin
         left_ff <= 4'h0;
      end else if (rif.load) begin
         left_ff <= 4'(`N_WORDS);
      end else if (rec_valid && rec_ready) begin
         left_ff <= left_ff - 4'h1;
      end
   end

   // shift register keeps the output word straight from a flop
   always_ff @(posedge clock) begin
      if (srst) begin
         for (int i = 0; i < `N_WORDS; i++) begin
            buf_ff[i] <= `WORD_ZERO;
         end
      end else if (rif.load) begin
         for (int i = 0; i < `N_FIELDS; i++) begin
            buf_ff[i] <= rif.att1[i];
            buf_ff[i + `N_FIELDS] <= rif.att2[i];
         end
      end else if (rec_valid && rec_ready) begin
         for (int i = 0; i < `N_WORDS - 1; i++) begin
            buf_ff[i] <= buf_ff[i + 1];
         end
         buf_ff[`N_WORDS - 1] <= `WORD_ZERO;
      end
   end

   AST_FIRST_WORD_IS_ATT1: assert property ( // R01
      @(posedge clock) disable iff (srst)
      rif.load |=> rec_valid && (rec_data == $past(rif.att1[`FLD_CNT_B])))
      else $error("first word after load is not the first attempt B count");

endmodule : record_serializer
`default_nettype wire

// *** rtl/totalize_sampler.sv ***
/*
   Two-channel totalize sample recorder. Counts events on channels A and B,
   keeps a 2 ns time datum, and on each accepted sample request emits two capture
   attempts through the record serializer, with pick flags that tell the
   consumer which attempt holds each channel's valid count.
   Assumes evt_a, evt_b and sample_req are one-cycle synchronous pulses, the
   fine-time value on interp_in is valid whenever a sample is taken, and the
   record consumer follows valid/ready.
*/
// Functional notes
// R01: each sample sends attempt one (B, A, unused, status) before attempt two.
// R02: attempt one status word carries only block-start and inhibit bits.
// R03: attempt two carries counts, time, fine time; pick A bit 13, B bit 14.
// R04: A pick flag zero: consumer uses attempt one A count as is.
// R05: A pick flag one: consumer uses attempt two A count minus one.
// R06: B pick flag zero: consumer uses attempt one B count as is.
// R07: B pick flag one: consumer uses attempt two B count minus one.
// R08: consumer corrects A and B count streams for rollover independently.
// R09: count below predecessor: consumer adds event overflow correction onward.
// R10: time below predecessor: consumer adds time overflow correction onward.
// R11: time and fine time appear only in attempt two, never in one.
// R12: time stamp is corrected time times 2 ns minus fine time times 0.1 ns.
// R13: channel result i is event stamp i+1 minus event stamp i.
// R14: combined measurements add channel results sample by sample.
// R15: gate time i is time stamp i+1 minus time stamp i.
// R16: overflow correction constants are consumer configuration inputs.
// R17: difference is A minus B; ratio is A divided by B, per sample.
`timescale 1ns/1ps
`default_nettype none
`include "sample_rec_map.svh"
module totalize_sampler
   import totalize_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire reg_addr_t reg_addr,
   input wire word_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output word_t reg_rdata,
   input wire logic evt_a,
   input wire logic evt_b,
   input wire logic sample_req,
   input wire interp_t interp_in,
   output logic rec_valid,
   output word_t rec_data,
   output logic rec_last,
   input wire logic rec_ready
);

   rec_if rif ();

   state_t state_ff;
   state_t nxt_state;

   logic en_ff;
   logic inh_ff;
   logic blk_pend_ff;
   logic miss_ff;
   logic clear;
   logic take;
   logic ld_ff;
   word_t rdata_ff;
   count_t samples_ff;
   count_t time_ff;
   count_t cnt_a;
   count_t cnt_b;

   // first attempt capture
   count_t ea1_ff;
   count_t eb1_ff;
   logic blk1_ff;
   logic inh1_ff;
   logic pick_a_ff;
   logic pick_b_ff;

   // second attempt capture
   count_t ea2_ff;
   count_t eb2_ff;
   count_t time2_ff;
   interp_t int2_ff;

   assign clear = reg_wr && (reg_addr == `REG_CTRL) && reg_wdata[`CTRL_CLR_BIT];

   // a sample is only taken while the serializer can accept it
   assign take = (state_ff == ST_IDLE) && sample_req && en_ff
                 && !rif.busy && !ld_ff;

   event_counter u_cnt_a (
      .clock(clock),
      .srst(srst),
      .clear(clear),
      .evt(evt_a),
      .count_ff(cnt_a)
   );

   event_counter u_cnt_b (
      .clock(clock),
      .srst(srst),
      .clear(clear),
      .evt(evt_b),
      .count_ff(cnt_b)
   );

   record_serializer u_ser (
      .clock(clock),
      .srst(srst),
      .rif(rif.snk),
      .rec_valid(rec_valid),
      .rec_data(rec_data),
      .rec_last(rec_last),
      .rec_ready(rec_ready)
   );

   // time datum in 2 ns units, wraps freely
   always_ff @(posedge clock) begin
      if (srst || clear) begin
         time_ff <= `WORD_ZERO;
      end else begin
         time_ff <= time_ff + 32'(`TIME_STEP);
      end
   end

   // control register
   always_ff @(posedge clock) begin
      if (srst) begin
         en_ff <= 1'b0;
         inh_ff <= 1'b0;
      end else if (reg_wr && (reg_addr == `REG_CTRL)) begin
         en_ff <= reg_wdata[`CTRL_EN_BIT];
         inh_ff <= reg_wdata[`CTRL_INH_BIT];
      end
   end

   // block start marks the next sample; a new request beats the clear
   always_ff @(posedge clock) begin
      if (srst) begin
         blk_pend_ff <= 1'b0;
      end else if (reg_wr && (reg_addr == `REG_CTRL) && reg_wdata[`CTRL_BLK_BIT]) begin
         blk_pend_ff <= 1'b1;
      end else if (take) begin
         blk_pend_ff <= 1'b0;
      end
   end

   // sticky miss: a request lost to a capture in progress or a busy serializer; set beats clear
   always_ff @(posedge clock) begin
      if (srst) begin
         miss_ff <= 1'b0;
      end else if (sample_req && en_ff && !take) begin
         miss_ff <= 1'b1;
      end else if (reg_wr && (reg_addr == `REG_STATUS) && reg_wdata[`STAT_MISS_BIT]) begin
         miss_ff <= 1'b0;
      end
   end

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (take) begin
               nxt_state = ST_CAP2;
            end
         end
         ST_CAP2: begin
            nxt_state = ST_IDLE;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // R01 first attempt capture
   // an event in the capture cycle makes attempt one uncertain, so the
   // pick flag sends the consumer to attempt two, taken one cycle later
   always_ff @(posedge clock) begin
      if (srst) begin
         ea1_ff <= `WORD_ZERO;
         eb1_ff <= `WORD_ZERO;
         blk1_ff <= 1'b0;
         inh1_ff <= 1'b0;
         pick_a_ff <= 1'b0;
         pick_b_ff <= 1'b0;
      end else if (take) begin
         ea1_ff <= cnt_a;
         eb1_ff <= cnt_b;
         blk1_ff <= blk_pend_ff;
         inh1_ff <= inh_ff;
         pick_a_ff <= evt_a;
         pick_b_ff <= evt_b;
      end
   end

   // R11 time only in second attempt
   always_ff @(posedge clock) begin
      if (srst) begin
         ea2_ff <= `WORD_ZERO;
         eb2_ff <= `WORD_ZERO;
         time2_ff <= `WORD_ZERO;
         int2_ff <= 12'h000;
      end else if (state_ff == ST_CAP2) begin
         ea2_ff <= cnt_a;
         eb2_ff <= cnt_b;
         time2_ff <= time_ff;
         int2_ff <= interp_in;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         ld_ff <= 1'b0;
      end else begin
         ld_ff <= (state_ff == ST_CAP2);
      end
   end

   always_ff @(posedge clock) begin
      if (srst || clear) begin
         samples_ff <= `WORD_ZERO;
      end else if (ld_ff) begin
         samples_ff <= samples_ff + `CNT_STEP;
      end
   end

   assign rif.load = ld_ff;

   // R01 attempt one fields
   // one process per word set, so no field has two drivers
   always_comb begin
      rif.att1[`FLD_CNT_B] = eb1_ff;
      rif.att1[`FLD_CNT_A] = ea1_ff;
      rif.att1[`FLD_TIME] = `WORD_ZERO;
      // R02 status bits only
      rif.att1[`FLD_STAT] = `WORD_ZERO;
      rif.att1[`FLD_STAT][`FLD_BLK_BIT] = blk1_ff;
      rif.att1[`FLD_STAT][`FLD_INH_BIT] = inh1_ff;
   end

   // R03 attempt two fields and pick flags
   always_comb begin
      rif.att2[`FLD_CNT_B] = eb2_ff;
      rif.att2[`FLD_CNT_A] = ea2_ff;
      rif.att2[`FLD_TIME] = time2_ff;
      rif.att2[`FLD_STAT] = {20'h00000, int2_ff};
      rif.att2[`FLD_STAT][`FLD_PICK_A_BIT] = pick_a_ff;
      rif.att2[`FLD_STAT][`FLD_PICK_B_BIT] = pick_b_ff;
   end

   // register read, answer one cycle later; unmapped reads zero
   always_ff @(posedge clock) begin
      if (srst) begin
         rdata_ff <= `WORD_ZERO;
      end else if (reg_rd) begin
         if (reg_addr == `REG_CTRL) begin
            rdata_ff <= {28'h0000000, 1'b0, blk_pend_ff, inh_ff, en_ff};
         end else if (reg_addr == `REG_STATUS) begin
            rdata_ff <= {30'h00000000, miss_ff, rif.busy || ld_ff || (state_ff != ST_IDLE)};
         end else if (reg_addr == `REG_SAMPLES) begin
            rdata_ff <= samples_ff;
         end else if (reg_addr == `REG_CNT_A) begin
            rdata_ff <= cnt_a;
         end else if (reg_addr == `REG_CNT_B) begin
            rdata_ff <= cnt_b;
         end else if (reg_addr == `REG_TIME) begin
            rdata_ff <= time_ff;
         end else begin
            rdata_ff <= `WORD_ZERO;
         end
      end else begin
         rdata_ff <= `WORD_ZERO;
      end
   end

   assign reg_rdata = rdata_ff;

   AST_TWO_ATTEMPTS: assert property ( // R01
      @(posedge clock) disable iff (srst)
      take |=> (state_ff == ST_CAP2) ##1 ld_ff)
      else $error("sample did not produce both attempts in order");

   AST_STAT1_ONLY_FLAGS: assert property ( // R02
      @(posedge clock) disable iff (srst)
      ld_ff |-> ((rif.att1[`FLD_STAT] & ~`FLD_STAT1_MASK) == `WORD_ZERO))
      else $error("first attempt status holds more than block and inhibit");

   AST_PICK_A_FLAG: assert property ( // R03
      @(posedge clock) disable iff (srst)
      take |-> ##2 (rif.att2[`FLD_STAT][`FLD_PICK_A_BIT] == $past(evt_a, 2)))
      else $error("channel A pick flag does not match capture race");

   AST_PICK_B_COUNT: assert property ( // R03
      @(posedge clock) disable iff (srst)
      ld_ff |-> (rif.att2[`FLD_CNT_B] == rif.att1[`FLD_CNT_B]
                 + {31'h00000000, rif.att2[`FLD_STAT][`FLD_PICK_B_BIT]}))
      else $error("channel B second attempt minus pick is not the valid count");

   AST_TIME_SECOND_ONLY: assert property ( // R11
      @(posedge clock) disable iff (srst)
      ld_ff |-> (rif.att1[`FLD_TIME] == `WORD_ZERO)
                && (rif.att2[`FLD_TIME] == $past(time_ff)))
      else $error("time datum not carried by the second attempt alone");

endmodule : totalize_sampler
`default_nettype wire

// *** test/rec_sink.sv ***
/*
   Host-side consumer of the sample record stream: takes eight words per
   sample, merges the two attempts and builds event and time stamps.
   Assumes the record source follows valid/ready on one common clock.
*/
`timescale 1ns/1ps
`default_nettype none
module rec_sink
   import totalize_pkg::*;
#(
   parameter longint EVT_CORR = 64'h1_0000_0000,
   parameter longint TIME_CORR = 64'h1_0000_0000
)
(
   input wire logic clock,
   input wire logic srst,
   input wire logic slow,
   input wire logic rec_valid,
   input wire word_t rec_data,
   input wire logic rec_last,
   output logic rec_ready
);
   word_t w [0:7];
   longint ea [0:31];
   longint eb [0:31];
   longint ts [0:31];
   int n;
   int idx;
   word_t pa, pb, pt;
   longint oa, ob, ot;

   task automatic merge();
      word_t a, b;
      a = w[7][13] ? w[5] - 32'h1 : w[1];
      b = w[7][14] ? w[4] - 32'h1 : w[0];
      if (n > 0 && a < pa) oa += EVT_CORR;
      if (n > 0 && b < pb) ob += EVT_CORR;
      if (n > 0 && w[6] < pt) ot += TIME_CORR;
      ea[n] = oa + a;
      eb[n] = ob + b;
      ts[n] = (ot + w[6]) * 2000 - w[7][11:0] * 100;
      pa = a;
      pb = b;
      pt = w[6];
      n++;
   endtask : merge

   always @(posedge clock) begin
      if (srst) begin
         n = 0;
         idx = 0;
         oa = 0;
         ob = 0;
         ot = 0;
         rec_ready <= 1'b1;
      end else begin
         // slow mode stalls every other cycle
         rec_ready <= slow ? !rec_ready : 1'b1;
         if (rec_valid && rec_ready) begin
            w[idx] = rec_data;
            idx++;
            if (rec_last) begin
               idx = 0;
               merge();
            end
         end
      end
   end
endmodule : rec_sink
`default_nettype wire

// *** test/testbench.sv ***
/*
   Self-checking bench for the totalize sample recorder.
   Assumes rec_sink stands on the record port as the host consumer.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin err_count++; \
   $display("BAD %0t got %0h exp %0h", $time, got, exp); end end
module testbench;
   import totalize_pkg::*;
   logic clock = 1'b0;
   logic srst = 1'b1;
   reg_addr_t reg_addr = 8'h00;
   word_t reg_wdata = 32'h0;
   logic reg_wr = 1'b0, reg_rd = 1'b0, evt_a = 1'b0, evt_b = 1'b0;
   logic sample_req = 1'b0, slow = 1'b0;
   interp_t interp_in = 12'h5A3;
   word_t reg_rdata, rec_data, rd;
   logic rec_valid, rec_last, rec_ready;
   int err_count = 0, checked = 0, cycles = 0, ca = 0, cb = 0, ns = 0;

   totalize_sampler uut (.clock(clock), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .evt_a(evt_a), .evt_b(evt_b), .sample_req(sample_req), .interp_in(interp_in),
      .rec_valid(rec_valid), .rec_data(rec_data), .rec_last(rec_last),
      .rec_ready(rec_ready));
   rec_sink snk (.clock(clock), .srst(srst), .slow(slow), .rec_valid(rec_valid),
      .rec_data(rec_data), .rec_last(rec_last), .rec_ready(rec_ready));

   always #5 clock = ~clock;

   task summarize();
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : summarize

   // run should end well before this
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         $display("BAD %0t timeout", $time);
         summarize();
      end
   end

   task reg_write(input reg_addr_t a, input word_t d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : reg_write

   task reg_read(input reg_addr_t a, output word_t d);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : reg_read

   task pulse(input int na, input int nb);
      for (int i = 0; i < 8; i++) begin
         @(posedge clock);
         evt_a <= (i < na);
         evt_b <= (i < nb);
      end
      @(posedge clock);
      evt_a <= 1'b0;
      evt_b <= 1'b0;
      ca += na;
      cb += nb;
   endtask : pulse

   task take(input logic pa, input logic pb);
      @(posedge clock);
      sample_req <= 1'b1;
      evt_a <= pa;
      evt_b <= pb;
      @(posedge clock);
      sample_req <= 1'b0;
      evt_a <= 1'b0;
      evt_b <= 1'b0;
   endtask : take

   task wait_n(input int k);
      for (int i = 0; i < 300 && snk.n < k; i++) @(negedge clock);
      `CHK(snk.n, k)
   endtask : wait_n

   task check_rec(input logic pa, input logic pb, input word_t st1);
      int k;
      k = snk.n - 1;
      `CHK(snk.w[0], word_t'(cb))
      `CHK(snk.w[1], word_t'(ca))
      `CHK(snk.w[2], 32'h0)
      `CHK(snk.w[3], st1)
      `CHK(snk.w[4], word_t'(cb + pb))
      `CHK(snk.w[5], word_t'(ca + pa))
      `CHK(snk.w[7], {17'h0, pb, pa, 1'b0, interp_in})
      `CHK(snk.ea[k], longint'(ca))
      `CHK(snk.eb[k], longint'(cb))
      ca += pa;
      cb += pb;
   endtask : check_rec

   task t_reset();
      reg_read(8'h00, rd);
      `CHK(rd, 32'h0)
      reg_read(8'h08, rd);
      `CHK(rd, 32'h0)
      reg_read(8'h40, rd);
      `CHK(rd, 32'h0)
      $display("reset test done");
   endtask : t_reset

   task t_picks();
      reg_write(8'h00, 32'h1);
      for (int i = 0; i < 4; i++) begin
         pulse(i + 1, 3 - i);
         take(i[0], i[1]);
         ns++;
         wait_n(ns);
         check_rec(i[0], i[1], 32'h0);
      end
      reg_read(8'h0C, rd);
      `CHK(rd, word_t'(ca))
      reg_read(8'h08, rd);
      `CHK(rd, word_t'(ns))
      $display("pick test done");
   endtask : t_picks

   task t_status();
      reg_write(8'h00, 32'h7);
      for (int i = 0; i < 2; i++) begin
         take(1'b0, 1'b0);
         ns++;
         wait_n(ns);
         // block start taken once, inhibit stays
         check_rec(1'b0, 1'b0, i == 0 ? 32'h9000 : 32'h1000);
      end
      reg_write(8'h00, 32'h1);
      $display("status test done");
   endtask : t_status

   task t_stall_miss();
      slow <= 1'b1;
      take(1'b1, 1'b1);
      repeat (3) @(posedge clock);
      take(1'b0, 1'b0);
      // serializer still busy at half rate, second request lost
      reg_read(8'h04, rd);
      `CHK(rd, 32'h3)
      ns++;
      wait_n(ns);
      check_rec(1'b1, 1'b1, 32'h0);
      repeat (30) @(negedge clock);
      `CHK(snk.n, ns)
      reg_read(8'h04, rd);
      `CHK(rd[1], 1'b1)
      reg_write(8'h04, 32'h2);
      reg_read(8'h04, rd);
      `CHK(rd[1], 1'b0)
      slow <= 1'b0;
      $display("stall test done");
   endtask : t_stall_miss

   task t_gate();
      int k;
      interp_in <= 12'h010;
      take(1'b0, 1'b0);
      // takes stand 20 cycles apart
      for (int i = 0; i < 18; i++) begin
         @(posedge clock);
         evt_a <= (i < 6);
         evt_b <= (i < 3);
         if (i == 5) interp_in <= 12'h020;
      end
      take(1'b0, 1'b0);
      ns += 2;
      wait_n(ns);
      k = snk.n - 1;
      `CHK(snk.ea[k] - snk.ea[k - 1], 64'h6)
      `CHK(snk.eb[k] - snk.eb[k - 1], 64'h3)
      `CHK((snk.ea[k] - snk.ea[k - 1]) + (snk.eb[k] - snk.eb[k - 1]), 64'h9)
      `CHK((snk.ea[k] - snk.ea[k - 1]) - (snk.eb[k] - snk.eb[k - 1]), 64'h3)
      `CHK((snk.ea[k] - snk.ea[k - 1]) / (snk.eb[k] - snk.eb[k - 1]), 64'h2)
      `CHK(snk.ts[k] - snk.ts[k - 1], 64'h30700)
      ca += 6;
      cb += 3;
      $display("gate test done");
   endtask : t_gate

   task t_clear();
      int k;
      word_t t0;
      reg_read(8'h14, t0);
      reg_read(8'h14, rd);
      // two cycles between the read edges
      `CHK(rd - t0, 32'hA)
      reg_read(8'h10, rd);
      `CHK(rd, word_t'(cb))
      reg_write(8'h00, 32'h9);
      ca = 0;
      cb = 0;
      pulse(2, 1);
      take(1'b0, 1'b0);
      ns++;
      wait_n(ns);
      k = snk.n - 1;
      // counts and time restart below their predecessors
      `CHK(snk.ea[k], 64'h1_0000_0002)
      `CHK(snk.eb[k], 64'h1_0000_0001)
      `CHK(snk.ts[k], (64'h1_0000_0037 * 64'h7D0) - 64'hC80)
      reg_read(8'h08, rd);
      `CHK(rd, 32'h1)
      reg_read(8'h00, rd);
      `CHK(rd, 32'h1)
      reg_read(8'h04, rd);
      `CHK(rd, 32'h0)
      $display("clear test done");
   endtask : t_clear

   initial begin
      repeat (3) @(posedge clock);
      srst <= 1'b0;
      t_reset();
      t_picks();
      t_status();
      t_stall_miss();
      t_gate();
      t_clear();
      summarize();
   end
endmodule : testbench
`default_nettype wire
